// ### src/pin_port_with_pwm.v
// eight-pin general purpose port with status routing and three pwm outputs
// assumes a serial control front end that delivers byte reads and writes
// on the system clock; channel flags and status inputs are on that clock.
`timescale 1ns/1ns
`include "pin_port_regs.vh"
module pin_port_with_pwm #(
  parameter PINS = 8
) (
  input  wire            clk,
  input  wire            reset,
  input  wire [7:0]      regAddr,
  input  wire            regWrite,
  input  wire [7:0]      regWriteData,
  input  wire            regRead,
  output reg  [7:0]      regReadData,
  input  wire [PINS-1:0] pinIn,
  output reg  [PINS-1:0] pinOut,
  output reg  [PINS-1:0] pinDriveEnable,
  output reg  [PINS-1:0] weakKeeperEnable,
  input  wire [7:0]      volumeMinFlags,
  input  wire [7:0]      automuteFlags,
  input  wire [7:0]      rampDoneFlags,
  input  wire            interruptLevel,
  input  wire            lockStatus,
  input  wire            idacClock,
  input  wire            oneFsEnable,
  input  wire [15:0]     pwm3PeriodDivider,
  output reg             powerDownRequest,
  output reg             fullPerformanceRequest,
  output reg             muteAllRequest,
  output reg             analogShutdownRequest
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg  [4*PINS-1:0] pinFunctionCode;
  reg  [PINS-1:0]   pinInputEnable;
  reg  [PINS-1:0]   outputInvert;
  reg  [PINS-1:0]   pinReadbackEnable;
  reg  [15:0]       flagLogic;
  reg  [7:0]        pwm1HighCount;
  reg  [15:0]       pwm1PeriodDivider;
  reg  [7:0]        pwm2HighCount;
  reg  [15:0]       pwm2PeriodDivider;
  reg  [7:0]        pwm3HighCount;

  wire [PINS-1:0]   pinSynced;
  wire [PINS-1:0]   pinSampledInput;
  wire [2:0]        pwmOut;
  wire [PINS-1:0]   next_pinOut;
  reg  [7:0]        next_readData;
  reg               next_powerDown;
  reg               next_fullPerformance;
  reg               next_muteAll;
  reg               next_shutdown;

  always @(posedge clk) begin
    if (reset) begin
      pinFunctionCode   <= {`RST_FUNC_OTHER, `RST_FUNC_OTHER, `RST_FUNC_OTHER, `RST_FUNC_PINS_1_2};
      pinDriveEnable    <= `RST_DRIVE_ENABLES;
      pinInputEnable    <= `RST_INPUT_ENABLES;
      weakKeeperEnable  <= `RST_KEEPER_ENABLES;
      outputInvert      <= `RST_OUTPUT_INVERT;
      pinReadbackEnable <= `RST_READBACK_ENABLES;
      flagLogic         <= `RST_FLAG_LOGIC;
      pwm1HighCount     <= `RST_PWM_HIGH;
      pwm1PeriodDivider <= `RST_PWM_DIV;
      pwm2HighCount     <= `RST_PWM_HIGH;
      pwm2PeriodDivider <= `RST_PWM_DIV;
      pwm3HighCount     <= `RST_PWM_HIGH;
    end else if (regWrite) begin
      if (regAddr == `ADDR_FUNC_PINS_1_2) begin
        pinFunctionCode[7:0] <= regWriteData;
      end else if (regAddr == `ADDR_FUNC_PINS_3_4) begin
        pinFunctionCode[15:8] <= regWriteData;
      end else if (regAddr == `ADDR_FUNC_PINS_5_6) begin
        pinFunctionCode[23:16] <= regWriteData;
      end else if (regAddr == `ADDR_FUNC_PINS_7_8) begin
        pinFunctionCode[31:24] <= regWriteData;
      end else if (regAddr == `ADDR_DRIVE_ENABLES) begin
        pinDriveEnable <= regWriteData;
      end else if (regAddr == `ADDR_INPUT_ENABLES) begin
        pinInputEnable <= regWriteData;
      end else if (regAddr == `ADDR_KEEPER_ENABLES) begin
        weakKeeperEnable <= regWriteData;
      end else if (regAddr == `ADDR_OUTPUT_INVERT) begin
        outputInvert <= regWriteData;
      end else if (regAddr == `ADDR_READBACK_ENABLES) begin
        pinReadbackEnable <= regWriteData;
      end else if (regAddr == `ADDR_FLAG_LOGIC_LO) begin
        flagLogic[7:0] <= regWriteData;
      end else if (regAddr == `ADDR_FLAG_LOGIC_HI) begin
        // bits 14:9 reserved, held at zero
        flagLogic[15:8] <= {regWriteData[7], 6'h00, regWriteData[0]};
      end else if (regAddr == `ADDR_PWM1_HIGH) begin
        pwm1HighCount <= regWriteData;
      end else if (regAddr == `ADDR_PWM1_DIV_LO) begin
        pwm1PeriodDivider[7:0] <= regWriteData;
      end else if (regAddr == `ADDR_PWM1_DIV_HI) begin
        pwm1PeriodDivider[15:8] <= regWriteData;
      end else if (regAddr == `ADDR_PWM2_HIGH) begin
        pwm2HighCount <= regWriteData;
      end else if (regAddr == `ADDR_PWM2_DIV_LO) begin
        pwm2PeriodDivider[7:0] <= regWriteData;
      end else if (regAddr == `ADDR_PWM2_DIV_HI) begin
        pwm2PeriodDivider[15:8] <= regWriteData;
      end else if (regAddr == `ADDR_PWM3_HIGH) begin
        pwm3HighCount <= regWriteData;
      end
    end
  end

  // ----------------------------------------------------------------
  // register readback
  // ----------------------------------------------------------------
  always @* begin
    next_readData = 8'h00;
    if (regAddr == `ADDR_FUNC_PINS_1_2) begin
      next_readData = pinFunctionCode[7:0];
    end else if (regAddr == `ADDR_FUNC_PINS_3_4) begin
      next_readData = pinFunctionCode[15:8];
    end else if (regAddr == `ADDR_FUNC_PINS_5_6) begin
      next_readData = pinFunctionCode[23:16];
    end else if (regAddr == `ADDR_FUNC_PINS_7_8) begin
      next_readData = pinFunctionCode[31:24];
    end else if (regAddr == `ADDR_DRIVE_ENABLES) begin
      next_readData = pinDriveEnable;
    end else if (regAddr == `ADDR_INPUT_ENABLES) begin
      next_readData = pinInputEnable;
    end else if (regAddr == `ADDR_KEEPER_ENABLES) begin
      next_readData = weakKeeperEnable;
    end else if (regAddr == `ADDR_OUTPUT_INVERT) begin
      next_readData = outputInvert;
    end else if (regAddr == `ADDR_READBACK_ENABLES) begin
      next_readData = pinReadbackEnable;
    end else if (regAddr == `ADDR_FLAG_LOGIC_LO) begin
      next_readData = flagLogic[7:0];
    end else if (regAddr == `ADDR_FLAG_LOGIC_HI) begin
      next_readData = flagLogic[15:8];
    end else if (regAddr == `ADDR_PWM1_HIGH) begin
      next_readData = pwm1HighCount;
    end else if (regAddr == `ADDR_PWM1_DIV_LO) begin
      next_readData = pwm1PeriodDivider[7:0];
    end else if (regAddr == `ADDR_PWM1_DIV_HI) begin
      next_readData = pwm1PeriodDivider[15:8];
    end else if (regAddr == `ADDR_PWM2_HIGH) begin
      next_readData = pwm2HighCount;
    end else if (regAddr == `ADDR_PWM2_DIV_LO) begin
      next_readData = pwm2PeriodDivider[7:0];
    end else if (regAddr == `ADDR_PWM2_DIV_HI) begin
      next_readData = pwm2PeriodDivider[15:8];
    end else if (regAddr == `ADDR_PWM3_HIGH) begin
      next_readData = pwm3HighCount;
    end else if (regAddr == `ADDR_PIN_LEVELS) begin
      // disabled pins read zero, not a stale level
      next_readData = pinSampledInput & pinReadbackEnable;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      regReadData <= 8'h00;
    end else if (regRead) begin
      regReadData <= next_readData;
    end
  end

  // ----------------------------------------------------------------
  // pin inputs
  // ----------------------------------------------------------------
  pin_sync #(
    .WIDTH   (PINS)
  ) u_pin_sync (
    .clk     (clk),
    .reset   (reset),
    .asyncIn (pinIn),
    .syncOut (pinSynced)
  );

  // a disabled input path reads low everywhere downstream
  assign pinSampledInput = pinSynced & pinInputEnable;

  // ----------------------------------------------------------------
  // pwm generators
  // ----------------------------------------------------------------
  pwm_generator u_pwm1 (
    .clk           (clk),
    .reset         (reset),
    .highCount     (pwm1HighCount),
    .periodDivider (pwm1PeriodDivider),
    .pwmOut        (pwmOut[0])
  );

  pwm_generator u_pwm2 (
    .clk           (clk),
    .reset         (reset),
    .highCount     (pwm2HighCount),
    .periodDivider (pwm2PeriodDivider),
    .pwmOut        (pwmOut[1])
  );

  pwm_generator u_pwm3 (
    .clk           (clk),
    .reset         (reset),
    .highCount     (pwm3HighCount),
    .periodDivider (pwm3PeriodDivider),
    .pwmOut        (pwmOut[2])
  );

  // ----------------------------------------------------------------
  // combined channel flags
  // ----------------------------------------------------------------
  wire [2:0] channelSel = flagLogic[`FL_SEL_HI:`FL_SEL_LO];
  wire       volMinFlag = flagLogic[`FL_OR_VOLMIN]     ? |volumeMinFlags :
                          flagLogic[`FL_AND_VOLMIN]    ? &volumeMinFlags :
                          volumeMinFlags[channelSel];
  wire       muteFlag   = flagLogic[`FL_OR_AUTOMUTE]   ? |automuteFlags :
                          flagLogic[`FL_AND_AUTOMUTE]  ? &automuteFlags :
                          automuteFlags[channelSel];
  wire       rampFlag   = flagLogic[`FL_OR_RAMP]       ? |rampDoneFlags :
                          flagLogic[`FL_AND_RAMP]      ? &rampDoneFlags :
                          rampDoneFlags[channelSel];

  // ----------------------------------------------------------------
  // per-pin output source
  // ----------------------------------------------------------------
  genvar p;
  generate
    for (p = 0; p < PINS; p = p + 1) begin : g_pin
      wire [3:0] code = pinFunctionCode[4*p+3:4*p];
      reg        source;
      always @* begin
        source = 1'b0;
        case (code)
          `FN_DRIVE_HIGH:    source = 1'b1;
          `FN_IDAC_CLOCK:    source = idacClock;
          `FN_INTERRUPT:     source = interruptLevel;
          `FN_LOCK_STATUS:   source = lockStatus;
          `FN_ONE_FS_ENABLE: source = oneFsEnable;
          `FN_PWM1:          source = pwmOut[0];
          `FN_PWM2:          source = pwmOut[1];
          `FN_PWM3:          source = pwmOut[2];
          `FN_VOLUME_MIN:    source = volMinFlag;
          `FN_AUTOMUTE:      source = muteFlag;
          `FN_RAMP_DONE:     source = rampFlag;
          default:           source = 1'b0;
        endcase
      end
      assign next_pinOut[p] = source ^ outputInvert[p];
    end
  endgenerate

  // ----------------------------------------------------------------
  // input-function pins
  // ----------------------------------------------------------------
  integer i;
  always @* begin
    next_powerDown       = 1'b0;
    next_fullPerformance = 1'b0;
    next_muteAll         = 1'b0;
    next_shutdown        = 1'b0;
    for (i = 0; i < PINS; i = i + 1) begin
      if (pinFunctionCode[4*i +: 4] == `FN_SYSTEM_MODE && pinSampledInput[i]) begin
        // pin low leaves the mode to the main mode register
        next_powerDown       = next_powerDown | ~flagLogic[`FL_DAC_MODE];
        next_fullPerformance = next_fullPerformance | flagLogic[`FL_DAC_MODE];
      end
      if (pinFunctionCode[4*i +: 4] == `FN_MUTE_ALL && pinSampledInput[i]) begin
        next_muteAll = 1'b1;
      end
      if (pinFunctionCode[4*i +: 4] == `FN_ANALOG_SHUTDOWN && pinSampledInput[i]) begin
        next_shutdown = 1'b1;
      end
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      pinOut                 <= {PINS{1'b0}};
      powerDownRequest       <= 1'b0;
      fullPerformanceRequest <= 1'b0;
      muteAllRequest         <= 1'b0;
      analogShutdownRequest  <= 1'b0;
    end else begin
      pinOut                 <= next_pinOut;
      powerDownRequest       <= next_powerDown;
      fullPerformanceRequest <= next_fullPerformance;
      muteAllRequest         <= next_muteAll;
      analogShutdownRequest  <= next_shutdown;
    end
  end
endmodule // pin_port_with_pwm

// ### src/pin_port_regs.vh
// register offsets, reset values and function codes of the pin port
// assumes byte-wide register access from the serial control front end
`ifndef PIN_PORT_REGS_VH
`define PIN_PORT_REGS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ADDR_FUNC_PINS_1_2      8'h25
`define ADDR_FUNC_PINS_3_4      8'h26
`define ADDR_FUNC_PINS_5_6      8'h27
`define ADDR_FUNC_PINS_7_8      8'h28
`define ADDR_DRIVE_ENABLES      8'h29
`define ADDR_INPUT_ENABLES      8'h2A
`define ADDR_KEEPER_ENABLES     8'h2B
`define ADDR_OUTPUT_INVERT      8'h2C
`define ADDR_READBACK_ENABLES   8'h2D
`define ADDR_FLAG_LOGIC_LO      8'h2E
`define ADDR_FLAG_LOGIC_HI      8'h2F
`define ADDR_PWM1_HIGH          8'h30
`define ADDR_PWM1_DIV_LO        8'h31
`define ADDR_PWM1_DIV_HI        8'h32
`define ADDR_PWM2_HIGH          8'h33
`define ADDR_PWM2_DIV_LO        8'h34
`define ADDR_PWM2_DIV_HI        8'h35
`define ADDR_PWM3_HIGH          8'h36
`define ADDR_PIN_LEVELS         8'hF0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_FUNC_PINS_1_2       8'h7D
`define RST_FUNC_OTHER          8'h00
`define RST_DRIVE_ENABLES       8'h03
`define RST_INPUT_ENABLES       8'h00
`define RST_KEEPER_ENABLES      8'h00
`define RST_OUTPUT_INVERT       8'h00
`define RST_READBACK_ENABLES    8'h00
`define RST_FLAG_LOGIC          16'h0007
`define RST_PWM_HIGH            8'h00
`define RST_PWM_DIV             16'h0000

// ----------------------------------------------------------------
// flag logic fields
// ----------------------------------------------------------------
`define FL_DAC_MODE             15
`define FL_SEL_HI               8
`define FL_SEL_LO               6
`define FL_OR_RAMP              5
`define FL_OR_VOLMIN            4
`define FL_OR_AUTOMUTE          3
`define FL_AND_RAMP             2
`define FL_AND_VOLMIN           1
`define FL_AND_AUTOMUTE         0

// ----------------------------------------------------------------
// pin function codes
// ----------------------------------------------------------------
`define FN_ANALOG_SHUTDOWN      4'h0
`define FN_DRIVE_LOW            4'h1
`define FN_DRIVE_HIGH           4'h2
`define FN_IDAC_CLOCK           4'h3
`define FN_INTERRUPT            4'h4
`define FN_MUTE_ALL             4'h5
`define FN_SYSTEM_MODE          4'h6
`define FN_LOCK_STATUS          4'h7
`define FN_ONE_FS_ENABLE        4'h8
`define FN_PWM1                 4'h9
`define FN_PWM2                 4'hA
`define FN_PWM3                 4'hB
`define FN_VOLUME_MIN           4'hC
`define FN_AUTOMUTE             4'hD
`define FN_RAMP_DONE            4'hE

`endif

// ### src/pin_sync.v
// two-flop synchroniser for a bus of independent pin levels
// assumes each bit is a slow level; bits are not coherent with each other
`timescale 1ns/1ns
module pin_sync #(
  parameter WIDTH = 8
) (
  input  wire             clk,
  input  wire             reset,
  input  wire [WIDTH-1:0] asyncIn,
  output reg  [WIDTH-1:0] syncOut
);
  reg [WIDTH-1:0] firstStage;

  always @(posedge clk) begin
    if (reset) begin
      firstStage <= {WIDTH{1'b0}};
      syncOut    <= {WIDTH{1'b0}};
    end else begin
      firstStage <= asyncIn;
      syncOut    <= firstStage;
    end
  end
endmodule // pin_sync

// ### src/pwm_generator.v
// one pwm generator on the system clock
// assumes settings come from registers in the same clock domain
`timescale 1ns/1ns
module pwm_generator #(
  parameter COUNT_WIDTH = 8,
  parameter DIV_WIDTH   = 16
) (
  input  wire                   clk,
  input  wire                   reset,
  input  wire [COUNT_WIDTH-1:0] highCount,
  input  wire [DIV_WIDTH-1:0]   periodDivider,
  output reg                    pwmOut
);
  reg  [DIV_WIDTH-1:0] phase;
  wire                 lastCycle = (phase >= periodDivider);

  // ----------------------------------------------------------------
  // period counter and output
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      phase  <= {DIV_WIDTH{1'b0}};
      pwmOut <= 1'b0;
    end else begin
      // period is divider plus one cycles
      if (lastCycle) begin
        phase <= {DIV_WIDTH{1'b0}};
      end else begin
        phase <= phase + {{(DIV_WIDTH-1){1'b0}}, 1'b1};
      end
      // high first; high count at or past period length stays high
      pwmOut <= ({{(DIV_WIDTH-COUNT_WIDTH){1'b0}}, highCount} > phase);
    end
  end
endmodule // pwm_generator

// ### verification/pin_port_with_pwm_assertions.sv
// concurrent checks on the pin port, seen only through its top-level ports
// assumes it is bound into pin_port_with_pwm; shadows track config writes at the ports
`timescale 1ns/1ns
`include "pin_port_regs.vh"
module pin_port_with_pwm_assertions #(
  parameter PINS = 8
) (
  input wire            clk,
  input wire            reset,
  input wire [7:0]      regAddr,
  input wire            regWrite,
  input wire [7:0]      regWriteData,
  input wire            regRead,
  input wire [7:0]      regReadData,
  input wire [PINS-1:0] pinOut,
  input wire [PINS-1:0] pinDriveEnable,
  input wire [PINS-1:0] weakKeeperEnable,
  input wire [7:0]      automuteFlags,
  input wire            powerDownRequest,
  input wire            fullPerformanceRequest
);
  // ----
  // shadow copies of the settings the checks depend on
  // ----
  reg  [3:0]  code1;
  reg  [15:0] flagLogic;
  reg         inv0;
  reg  [7:0]  inEn;
  reg  [7:0]  rbEn;
  wire [2:0]  sel = flagLogic[8:6];
  wire        amExpect = flagLogic[3] ? |automuteFlags : (flagLogic[0] ? &automuteFlags : automuteFlags[sel]);
  always @(posedge clk) begin
    if (reset) begin
      code1 <= 4'hD;
      flagLogic <= `RST_FLAG_LOGIC;
      inv0 <= 1'b0;
      inEn <= 8'h00;
      rbEn <= 8'h00;
    end else if (regWrite) begin
      if (regAddr == `ADDR_FUNC_PINS_1_2) code1 <= regWriteData[3:0];
      if (regAddr == `ADDR_FLAG_LOGIC_LO) flagLogic[7:0] <= regWriteData;
      if (regAddr == `ADDR_FLAG_LOGIC_HI) flagLogic[15:8] <= regWriteData;
      if (regAddr == `ADDR_OUTPUT_INVERT) inv0 <= regWriteData[0];
      if (regAddr == `ADDR_INPUT_ENABLES) inEn <= regWriteData;
      if (regAddr == `ADDR_READBACK_ENABLES) rbEn <= regWriteData;
    end
  end
  // ----
  // properties
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence keeperWrite;
    regWrite && regAddr == `ADDR_KEEPER_ENABLES;
  endsequence
  sequence driveWrite;
    regWrite && regAddr == `ADDR_DRIVE_ENABLES;
  endsequence
  sequence levelRead;
    regRead && regAddr == `ADDR_PIN_LEVELS;
  endsequence
  reset_values_a: assert property ($fell(reset) |-> pinDriveEnable == 8'h03 && weakKeeperEnable == 8'h00)
    else $error("outputs not at reset values");
  keeper_write_a: assert property (keeperWrite |=> weakKeeperEnable == $past(regWriteData))
    else $error("keeper enables do not follow the write");
  drive_write_a: assert property (driveWrite |=> pinDriveEnable == $past(regWriteData))
    else $error("drive enables do not follow the write");
  readback_gate_a: assert property (levelRead |=> (regReadData & ~($past(inEn) & $past(rbEn))) == 8'h00)
    else $error("pin level read through a closed gate");
  unmapped_read_a: assert property (regRead && regAddr == 8'h80 |=> regReadData == 8'h00)
    else $error("unmapped read not zero");
  read_hold_a: assert property (!regRead |=> $stable(regReadData))
    else $error("read data moved without a read");
  automute_route_a: assert property (!$past(reset) && $past(code1) == `FN_AUTOMUTE |->
    pinOut[0] == ($past(amExpect) ^ $past(inv0))) else $error("automute routing wrong on pin 1");
  power_exclusive_a: assert property (!(powerDownRequest && fullPerformanceRequest))
    else $error("both system mode requests high");
endmodule // pin_port_with_pwm_assertions

// ### verification/pin_partner.sv
// board circuitry on the eight pins: resolves each wire level for the port
// assumes the bench forces pins through extDrive/extLevel only while undriven
`timescale 1ns/1ns
module pin_partner (
  input  wire       clk,
  input  wire [7:0] pinOut,
  input  wire [7:0] pinDriveEnable,
  input  wire [7:0] weakKeeperEnable,
  input  wire [7:0] extDrive,
  input  wire [7:0] extLevel,
  output reg  [7:0] pinIn
);
  reg [7:0] lastLevel;
  integer   i;
  initial lastLevel = 8'h00;
  always @* begin
    for (i = 0; i < 8; i = i + 1) begin
      if (pinDriveEnable[i]) pinIn[i] = pinOut[i];
      else if (extDrive[i]) pinIn[i] = extLevel[i];
      else if (weakKeeperEnable[i]) pinIn[i] = lastLevel[i];
      // floating wire toggles so no settled guess can pass
      else pinIn[i] = ~lastLevel[i];
    end
  end
  always @(posedge clk) lastLevel <= pinIn;
endmodule // pin_partner

// ### verification/pin_port_with_pwm_tb_top.sv
// self-checking bench for the pin port through its byte register access
// assumes 10 MHz clock, synchronous reset, partner model on the pins
`timescale 1ns/1ns
`include "pin_port_regs.vh"
module pin_port_with_pwm_tb_top;
  logic        clk, reset, regWrite, regRead;
  logic [7:0]  regAddr, regWriteData, regReadData, got, f;
  logic [7:0]  pinIn, pinOut, pinDriveEnable, weakKeeperEnable, extDrive, extLevel;
  logic [7:0]  volumeMinFlags, automuteFlags, rampDoneFlags;
  logic [15:0] pwm3PeriodDivider;
  logic        powerDownRequest, fullPerformanceRequest, muteAllRequest, analogShutdownRequest;
  int          badCount, compares, cycles, i, j, h1, r1, h2, h3;
  logic        prev;
  logic [3:0]  misc;
  logic [7:0]  rstAddr [0:15] = '{8'h25, 8'h29, 8'h2A, 8'h2B, 8'h2C, 8'h2D, 8'h2E, 8'h2F,
                                   8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h80};
  logic [7:0]  rstVal [0:15] = '{8'h7D, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h07, 8'h00,
                                  8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0]  rwAddr [0:5] = '{8'h2B, 8'h2D, 8'h29, 8'h30, 8'h34, 8'h35};
  // expected pin 1 level, code, flag logic low, high, flags
  logic [31:0] flagCase [0:12] = '{32'h1D080001, 32'h1D0100FF, 32'h0D01007F, 32'h1D000001, 32'h0D000002,
    32'h1D090001, 32'h1C100001, 32'h0C0200FE, 32'h1C800140, 32'h1E200080, 32'h1E0400FF, 32'h1EC00180,
    32'h0EC0017F};
  // highs in 20 cycles = (20 / period) periods x high count, each capped at the period
  logic [7:0]  pwmHigh1 [0:1] = '{8'h03, 8'hFF};
  logic [7:0]  pwmDiv1 [0:1] = '{8'h09, 8'h00};
  logic [7:0]  pwmHigh2 [0:1] = '{8'h0C, 8'h00};
  int          expH1 [0:1] = '{6, 20};
  int          expR1 [0:1] = '{2, 0};
  int          expH2 [0:1] = '{20, 0};

  pin_port_with_pwm #(.PINS(8)) u_dut (.clk(clk), .reset(reset), .regAddr(regAddr), .regWrite(regWrite),
    .regWriteData(regWriteData), .regRead(regRead), .regReadData(regReadData), .pinIn(pinIn),
    .pinOut(pinOut), .pinDriveEnable(pinDriveEnable), .weakKeeperEnable(weakKeeperEnable),
    .volumeMinFlags(volumeMinFlags), .automuteFlags(automuteFlags), .rampDoneFlags(rampDoneFlags),
    .interruptLevel(misc[0]), .lockStatus(misc[1]), .idacClock(misc[2]), .oneFsEnable(misc[3]),
    .pwm3PeriodDivider(pwm3PeriodDivider), .powerDownRequest(powerDownRequest),
    .fullPerformanceRequest(fullPerformanceRequest), .muteAllRequest(muteAllRequest),
    .analogShutdownRequest(analogShutdownRequest));
  pin_partner u_partner (.clk(clk), .pinOut(pinOut), .pinDriveEnable(pinDriveEnable),
    .weakKeeperEnable(weakKeeperEnable), .extDrive(extDrive), .extLevel(extLevel), .pinIn(pinIn));

  always #50 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      badCount = badCount + 1;
      closeOut;
    end
  end
  // ----
  // access and compare tasks
  // ----
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 regAddr = a;
    regWriteData = d;
    regWrite = 1'b1;
    @(posedge clk);
    #1 regWrite = 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1 regAddr = a;
    regRead = 1'b1;
    @(posedge clk);
    #1 regRead = 1'b0;
    d = regReadData;
  endtask
  task chk(input logic [7:0] g, input logic [7:0] e);
    compares = compares + 1;
    if (g !== e) begin
      badCount = badCount + 1;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask
  task settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task closeOut;
    if (badCount == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    clk = 1'b0; reset = 1'b1; regAddr = 8'h00; regWrite = 1'b0; regWriteData = 8'h00; regRead = 1'b0;
    extDrive = 8'h00; extLevel = 8'h00; volumeMinFlags = 8'h00; automuteFlags = 8'h00;
    rampDoneFlags = 8'h00; pwm3PeriodDivider = 16'h0000; badCount = 0; compares = 0; cycles = 0;
    misc = 4'h0;
    repeat (6) @(posedge clk);
    #1 reset = 1'b0;
    for (i = 0; i < 16; i++) begin
      rd(rstAddr[i], got);
      chk(got, rstVal[i]);
    end
    for (i = 0; i < 6; i++) begin
      wr(rwAddr[i], 8'h5A);
      rd(rwAddr[i], got);
      chk(got, 8'h5A);
      wr(rwAddr[i], 8'h00);
    end
    wr(`ADDR_DRIVE_ENABLES, 8'h03);
    // pin 4 held high from outside, gated by input and readback enables
    extDrive = 8'h08;
    extLevel = 8'h08;
    wr(`ADDR_READBACK_ENABLES, 8'h08);
    settle(3);
    rd(`ADDR_PIN_LEVELS, got);
    chk(got, 8'h00);
    wr(`ADDR_INPUT_ENABLES, 8'h08);
    settle(3);
    rd(`ADDR_PIN_LEVELS, got);
    chk(got, 8'h08);
    chk({7'h00, analogShutdownRequest}, 8'h01);
    wr(`ADDR_READBACK_ENABLES, 8'h00);
    rd(`ADDR_PIN_LEVELS, got);
    chk(got, 8'h00);
    wr(`ADDR_INPUT_ENABLES, 8'h00);
    for (i = 0; i < 13; i++) begin
      f = flagCase[i][7:0];
      volumeMinFlags = (flagCase[i][27:24] == `FN_VOLUME_MIN) ? f : ~f;
      automuteFlags = (flagCase[i][27:24] == `FN_AUTOMUTE) ? f : ~f;
      rampDoneFlags = (flagCase[i][27:24] == `FN_RAMP_DONE) ? f : ~f;
      wr(`ADDR_FUNC_PINS_1_2, {4'h7, flagCase[i][27:24]});
      wr(`ADDR_FLAG_LOGIC_LO, flagCase[i][23:16]);
      wr(`ADDR_FLAG_LOGIC_HI, flagCase[i][15:8]);
      settle(2);
      chk({7'h00, pinOut[0]}, {4'h0, flagCase[i][31:28]});
    end
    wr(`ADDR_OUTPUT_INVERT, 8'h01);
    settle(2);
    chk({7'h00, pinOut[0]}, 8'h01);
    wr(`ADDR_OUTPUT_INVERT, 8'h00);
    wr(`ADDR_FUNC_PINS_3_4, 8'hA9);
    wr(`ADDR_FUNC_PINS_5_6, 8'h6B);
    // pwm3: period 5 with high 2, then period 2 with high 2 (high equals period)
    wr(`ADDR_PWM3_HIGH, 8'h02);
    for (j = 0; j < 2; j++) begin
      pwm3PeriodDivider = j ? 16'h0001 : 16'h0004;
      wr(`ADDR_PWM1_HIGH, pwmHigh1[j]);
      wr(`ADDR_PWM1_DIV_LO, pwmDiv1[j]);
      wr(`ADDR_PWM2_HIGH, pwmHigh2[j]);
      wr(`ADDR_PWM2_DIV_LO, 8'h04);
      settle(20);
      h1 = 0; r1 = 0; h2 = 0; h3 = 0; prev = pinOut[2];
      for (i = 0; i < 20; i++) begin
        settle(1);
        h1 += pinOut[2];
        r1 += (pinOut[2] && !prev);
        h2 += pinOut[3];
        h3 += pinOut[4];
        prev = pinOut[2];
      end
      chk(h1[7:0], expH1[j][7:0]);
      chk(r1[7:0], expR1[j][7:0]);
      chk(h2[7:0], expH2[j][7:0]);
      chk(h3[7:0], j ? 8'h14 : 8'h08);
    end
    // pin 6 as system mode input, both polarities, then driven low from outside
    extDrive = 8'h20;
    extLevel = 8'h20;
    wr(`ADDR_INPUT_ENABLES, 8'h20);
    settle(4);
    chk({6'h00, powerDownRequest, fullPerformanceRequest}, 8'h02);
    wr(`ADDR_FLAG_LOGIC_HI, 8'h80);
    settle(4);
    chk({6'h00, powerDownRequest, fullPerformanceRequest}, 8'h01);
    extLevel = 8'h00;
    settle(4);
    chk({6'h00, powerDownRequest, fullPerformanceRequest}, 8'h00);
    // pin 6 as mute-all input, pin 2 routing lock status then interrupt
    extLevel = 8'h20;
    misc = 4'h2;
    wr(`ADDR_FUNC_PINS_5_6, 8'h5B);
    settle(4);
    chk({5'h00, muteAllRequest, powerDownRequest, fullPerformanceRequest}, 8'h04);
    chk({7'h00, pinOut[1]}, 8'h01);
    wr(`ADDR_FUNC_PINS_1_2, 8'h4E);
    settle(2);
    chk({7'h00, pinOut[1]}, 8'h00);
    closeOut;
  end
endmodule // pin_port_with_pwm_tb_top

bind pin_port_with_pwm pin_port_with_pwm_assertions #(.PINS(PINS)) u_chk (.clk(clk), .reset(reset),
  .regAddr(regAddr), .regWrite(regWrite), .regWriteData(regWriteData), .regRead(regRead),
  .regReadData(regReadData), .pinOut(pinOut), .pinDriveEnable(pinDriveEnable),
  .weakKeeperEnable(weakKeeperEnable), .automuteFlags(automuteFlags), .powerDownRequest(powerDownRequest),
  .fullPerformanceRequest(fullPerformanceRequest));
